// [hw/fsrh_pkg.sv]
// Purpose: constants for the flash soft reset handler
// Assumes: pclk at 50 MHz
// Notes: register offsets are byte addresses on APB
package fsrh_pkg;
  localparam int unsigned PCLK_HZ = 50000000;
  // power-up wait in microseconds (1.8 ms)
  localparam int unsigned PWRUP_US = 1800;
  localparam int unsigned PWRUP_CYC = (PWRUP_US * (PCLK_HZ / 1000000));
  // reset recovery times, plain defaults in microseconds
  localparam int unsigned RST_US = 30;
  localparam int unsigned RST_E_US = 1000;
  localparam int unsigned RST_CYC = RST_US * (PCLK_HZ / 1000000);
  localparam int unsigned RST_E_CYC = RST_E_US * (PCLK_HZ / 1000000);
  // suspend time for busy to clear
  localparam int unsigned SUS_US = 20;
  localparam int unsigned SUS_CYC = SUS_US * (PCLK_HZ / 1000000);
  localparam logic [7:0] OP_EN_RST = 8'h66;
  localparam logic [7:0] OP_RST = 8'h99;
  localparam logic [7:0] OP_SUSPEND = 8'h75;
  localparam logic [7:0] OP_RESUME = 8'h7A;
  localparam logic [7:0] OP_DEEP_PD = 8'hB9;
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_ERASE = 8'h20;
  localparam logic [7:0] OP_PROG = 8'h02;
  localparam logic [7:0] ARRAY_ERASED = 8'hFF;
  // status word layout
  localparam int unsigned ST_BUSY = 0;
  localparam int unsigned ST_WEL = 1;
  localparam int unsigned ST_SUS_ERASE = 15;
  localparam int unsigned ST_SUS_PROG = 10;
  localparam int unsigned ST_OUTPUT_DRIVE_STRENGTH_BIT = 21;
  localparam logic [23:0] STATUS_RESET = 24'h200000;
  // register byte offsets
  localparam logic [7:0] A_STATUS = 8'h00;
  localparam logic [7:0] A_VOLATILE = 8'h04;
  localparam logic [7:0] A_CTRL = 8'h08;
  localparam logic [7:0] A_STATE = 8'h0C;
  localparam logic [7:0] A_OPCOUNT = 8'h10;
  localparam int unsigned C_START_ERASE = 0;
  localparam int unsigned C_START_PROG = 1;
  localparam int unsigned C_DONE = 2;
  localparam logic [31:0] RD_ZERO = 32'h00000000;
endpackage

// [hw/fsrh_link.sv]
// Purpose: serial opcode capture on the link clock
// Assumes: mode 0 serial, frame delimited by chip select
// Notes: one toggle per completed eight-bit frame
`timescale 1ns/1ns
module fsrh_link (
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic si,
  input wire logic rst_n,
  output logic [7:0] op,
  output logic op_tog
);
  logic [7:0] shift;
  logic [3:0] cnt;
  logic [7:0] next_shift;
  logic [3:0] next_cnt;
  logic [7:0] next_op;
  logic next_op_tog;
  // the frame ends by chip select itself, so no sclk edge after the frame is needed
  always_comb begin
    next_shift = {shift[6:0], si};
    next_cnt = (cnt == 4'hF) ? cnt : cnt + 4'h1;
  end
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      shift <= 8'h00;
      cnt <= 4'h0;
    end else begin
      shift <= next_shift;
      cnt <= next_cnt;
    end
  end
  always_comb begin
    next_op = op;
    next_op_tog = op_tog;
    if (cnt == 4'h8) begin
      next_op = shift;
      next_op_tog = ~op_tog;
    end
  end
  // reset to the synchroniser's idle level so no false frame event follows reset
  always_ff @(posedge cs_n or negedge rst_n) begin
    if (!rst_n) begin
      op <= 8'h00;
      op_tog <= 1'b0;
    end else begin
      op <= next_op;
      op_tog <= next_op_tog;
    end
  end
endmodule

// [hw/fsrh_top.sv]
// Purpose: soft reset handling of a serial flash device
// Assumes: pclk 50 MHz, link clock from host, APB registers
// Notes: array contents are outside this block
// What this block does
// - enable-reset frame then reset frame triggers reset
// - accepted reset aborts work, restores power-on state
// - accepted reset clears all volatile settings
// - refuse commands during reset recovery interval
// - reset during program or erase risks data
// - delivered state: array ones, status drive bit
// - no commands before power-up wait ends
// - busy reads one during self-timed cycle
// - suspend sets flag at once, busy clears
// - serial bits captured on rising clock edges
//
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/1ns
module fsrh_top #(
  parameter int unsigned PWRUP_CYC = fsrh_pkg::PWRUP_CYC,
  parameter int unsigned RST_CYC = fsrh_pkg::RST_CYC,
  parameter int unsigned RST_E_CYC = fsrh_pkg::RST_E_CYC,
  parameter int unsigned SUS_CYC = fsrh_pkg::SUS_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic si,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic busy_flag,
  output logic ready,
  output logic reset_pulse,
  output logic data_suspect
);
  typedef enum logic [3:0] {
    FSRH_PWRUP = 4'h1,
    FSRH_IDLE = 4'h2,
    FSRH_ARMED = 4'h4,
    FSRH_RECOVER = 4'h8
  } fsrh_state_t;
  typedef enum logic [2:0] {
    FSRH_OP_NONE = 3'h1,
    FSRH_OP_RUN = 3'h2,
    FSRH_OP_SUSPEND = 3'h4
  } fsrh_op_t;

  ////////////////////////////////////////////////////////////////////////////////
  // link
  logic [7:0] link_op;
  logic link_tog;
  fsrh_link u_link (
    .sclk(sclk),
    .cs_n(cs_n),
    .si(si),
    .rst_n(presetn),
    .op(link_op),
    .op_tog(link_tog)
  );
  // op is stable long before the toggle is seen after two flops
  logic [2:0] tog_sync;
  logic [7:0] op_s1;
  logic [7:0] op_s2;
  logic frame_evt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tog_sync <= 3'h0;
      op_s1 <= 8'h00;
      op_s2 <= 8'h00;
    end else begin
      tog_sync <= {tog_sync[1:0], link_tog};
      op_s1 <= link_op;
      op_s2 <= op_s1;
    end
  end
  assign frame_evt = tog_sync[2] ^ tog_sync[1];

  ////////////////////////////////////////////////////////////////////////////////
  // control state
  fsrh_state_t state;
  fsrh_state_t next_state;
  fsrh_op_t op_st;
  fsrh_op_t next_op_st;
  logic op_is_erase;
  logic next_op_is_erase;
  logic [23:0] status;
  logic [23:0] next_status;
  logic [31:0] volat;
  logic [31:0] next_volat;
  logic deep_pd;
  logic next_deep_pd;
  logic [31:0] timer;
  logic [31:0] next_timer;
  logic [31:0] sus_timer;
  logic [31:0] next_sus_timer;
  logic [15:0] opcount;
  logic [15:0] next_opcount;
  logic next_reset_pulse;
  logic next_data_suspect;
  logic wr_ctrl;
  logic accept;
  logic do_reset;

  assign wr_ctrl = psel && penable && pwrite && (paddr == fsrh_pkg::A_CTRL);
  // commands only count once out of power-up and recovery
  assign accept = frame_evt && !deep_pd &&
    (state == FSRH_IDLE || state == FSRH_ARMED);
  assign do_reset = accept && state == FSRH_ARMED && op_s2 == fsrh_pkg::OP_RST;

  always_comb begin
    next_state = state;
    next_op_st = op_st;
    next_op_is_erase = op_is_erase;
    next_status = status;
    next_volat = volat;
    next_deep_pd = deep_pd;
    next_timer = (timer != 32'h0) ? timer - 32'h1 : timer;
    next_sus_timer = (sus_timer != 32'h0) ? sus_timer - 32'h1 : sus_timer;
    next_opcount = accept ? opcount + 16'h1 : opcount;
    next_reset_pulse = 1'b0;
    next_data_suspect = data_suspect;
    case (state)
      FSRH_PWRUP: begin
        if (timer == 32'h0) begin
          next_state = FSRH_IDLE;
        end
      end
      FSRH_IDLE: begin
        if (accept && op_s2 == fsrh_pkg::OP_EN_RST) begin
          next_state = FSRH_ARMED;
        end
      end
      FSRH_ARMED: begin
        if (do_reset) begin
          next_state = FSRH_RECOVER;
          next_timer = op_is_erase && op_st != FSRH_OP_NONE ? RST_E_CYC : RST_CYC;
          next_data_suspect = (op_st != FSRH_OP_NONE);
          next_reset_pulse = 1'b1;
          next_op_st = FSRH_OP_NONE;
          next_status = fsrh_pkg::STATUS_RESET;
          next_volat = 32'h0;
          next_sus_timer = 32'h0;
        end else if (accept && op_s2 != fsrh_pkg::OP_EN_RST) begin
          next_state = FSRH_IDLE;
        end
      end
      FSRH_RECOVER: begin
        if (timer == 32'h0) begin
          next_state = FSRH_IDLE;
        end
      end
      default: next_state = FSRH_PWRUP;
    endcase
    if (accept && !do_reset) begin
      case (op_s2)
        fsrh_pkg::OP_WREN: next_status[fsrh_pkg::ST_WEL] = 1'b1;
        fsrh_pkg::OP_DEEP_PD: next_deep_pd = 1'b1;
        fsrh_pkg::OP_SUSPEND: begin
          if (op_st == FSRH_OP_RUN) begin
            next_op_st = FSRH_OP_SUSPEND;
            next_status[op_is_erase ? fsrh_pkg::ST_SUS_ERASE : fsrh_pkg::ST_SUS_PROG] = 1'b1;
            next_sus_timer = SUS_CYC;
          end
        end
        fsrh_pkg::OP_RESUME: begin
          if (op_st == FSRH_OP_SUSPEND) begin
            next_op_st = FSRH_OP_RUN;
            next_status[fsrh_pkg::ST_SUS_ERASE] = 1'b0;
            next_status[fsrh_pkg::ST_SUS_PROG] = 1'b0;
            next_status[fsrh_pkg::ST_BUSY] = 1'b1;
          end
        end
        default: next_op_st = next_op_st;
      endcase
    end
    // busy drops at the end of the suspend time
    if (op_st == FSRH_OP_SUSPEND && sus_timer == 32'h1) begin
      next_status[fsrh_pkg::ST_BUSY] = 1'b0;
    end
    // software models the array engine: start and finish of a self-timed cycle
    if (wr_ctrl && state == FSRH_IDLE && op_st == FSRH_OP_NONE &&
        (pwdata[fsrh_pkg::C_START_ERASE] || pwdata[fsrh_pkg::C_START_PROG])) begin
      next_op_st = FSRH_OP_RUN;
      next_op_is_erase = pwdata[fsrh_pkg::C_START_ERASE];
      next_status[fsrh_pkg::ST_BUSY] = 1'b1;
      next_data_suspect = 1'b0;
    end else if (wr_ctrl && pwdata[fsrh_pkg::C_DONE] && op_st == FSRH_OP_RUN) begin
      next_op_st = FSRH_OP_NONE;
      next_status[fsrh_pkg::ST_BUSY] = 1'b0;
      next_status[fsrh_pkg::ST_WEL] = 1'b0;
    end
    if (psel && penable && pwrite && paddr == fsrh_pkg::A_VOLATILE && !do_reset) begin
      next_volat = pwdata;
    end
    if (do_reset) begin
      next_deep_pd = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= FSRH_PWRUP;
      op_st <= FSRH_OP_NONE;
      op_is_erase <= 1'b0;
      status <= fsrh_pkg::STATUS_RESET;
      volat <= 32'h0;
      deep_pd <= 1'b0;
      timer <= PWRUP_CYC;
      sus_timer <= 32'h0;
      opcount <= 16'h0;
      reset_pulse <= 1'b0;
      data_suspect <= 1'b0;
    end else begin
      state <= next_state;
      op_st <= next_op_st;
      op_is_erase <= next_op_is_erase;
      status <= next_status;
      volat <= next_volat;
      deep_pd <= next_deep_pd;
      timer <= next_timer;
      sus_timer <= next_sus_timer;
      opcount <= next_opcount;
      reset_pulse <= next_reset_pulse;
      data_suspect <= next_data_suspect;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // apb read side, zero wait states
  logic [31:0] next_prdata;
  logic next_busy;
  logic next_ready;
  always_comb begin
    next_prdata = prdata;
    next_busy = next_status[fsrh_pkg::ST_BUSY];
    next_ready = (next_state == FSRH_IDLE) || (next_state == FSRH_ARMED);
    if (psel && !penable && !pwrite) begin
      case (paddr)
        fsrh_pkg::A_STATUS: next_prdata = {8'h00, status};
        fsrh_pkg::A_VOLATILE: next_prdata = volat;
        fsrh_pkg::A_CTRL: next_prdata = {31'h0, data_suspect};
        fsrh_pkg::A_STATE: next_prdata = {24'h0, deep_pd, op_st, state};
        fsrh_pkg::A_OPCOUNT: next_prdata = {16'h0, opcount};
        default: next_prdata = fsrh_pkg::RD_ZERO;
      endcase
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      busy_flag <= 1'b0;
      ready <= 1'b0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata <= next_prdata;
      busy_flag <= next_busy;
      ready <= next_ready;
      pready <= psel && !penable;
      pslverr <= psel && !penable && paddr > fsrh_pkg::A_OPCOUNT;
    end
  end
endmodule

// [bench/fsrh_top_assertions.sv]
// Purpose: port checks for fsrh_top
// Assumes: bench runs with reduced counts
// Notes: recovery bound allows a few crossing cycles
`timescale 1ns/1ns
module fsrh_chk #(
  parameter int unsigned PWRUP_CYC = 50,
  parameter int unsigned RST_CYC = 20,
  parameter int unsigned RST_E_CYC = 40
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic busy_flag,
  input wire logic ready,
  input wire logic reset_pulse,
  input wire logic data_suspect
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  int unsigned up_cnt;
  int unsigned rec_cnt;
  logic rec_on;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up_cnt <= 0;
      rec_cnt <= 0;
      rec_on <= 1'b0;
    end else begin
      // saturate so a long run cannot wrap the power-up count
      if (up_cnt < PWRUP_CYC) up_cnt <= up_cnt + 1;
      if (reset_pulse) rec_cnt <= 0;
      else if (rec_on) rec_cnt <= rec_cnt + 1;
      if (reset_pulse) rec_on <= 1'b1;
      else if (ready) rec_on <= 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  pulse_once_a: assert property (reset_pulse |=> !reset_pulse)
    else $error("reset pulse too long");
  ready_drop_a: assert property (reset_pulse |=> !ready)
    else $error("ready held after reset");
  pulse_ready_a: assert property (reset_pulse |-> $past(ready))
    else $error("reset accepted while refusing");
  busy_abort_a: assert property (reset_pulse |-> ##[0:2] !busy_flag)
    else $error("busy survived reset");
  suspect_a: assert property (reset_pulse && $past(busy_flag) |-> ##[0:2] data_suspect)
    else $error("suspect flag missing");
  rec_window_a: assert property ($rose(ready) && rec_on |->
    rec_cnt + 1 >= RST_CYC && rec_cnt <= RST_E_CYC + 8) else $error("recovery length wrong");
  pwrup_a: assert property (ready |-> up_cnt + 1 >= PWRUP_CYC)
    else $error("ready before power-up wait");
  pwrup_idle_a: assert property (up_cnt < PWRUP_CYC |-> !busy_flag)
    else $error("busy during power-up");
endmodule
bind fsrh_top fsrh_chk #(.PWRUP_CYC(PWRUP_CYC), .RST_CYC(RST_CYC), .RST_E_CYC(RST_E_CYC))
  fsrh_chk_i (.pclk(pclk), .presetn(presetn), .busy_flag(busy_flag), .ready(ready),
  .reset_pulse(reset_pulse), .data_suspect(data_suspect));

// [bench/fsrh_host.sv]
// Purpose: host side of the serial link
// Assumes: mode 0, msb first, 32 ns link clock
// Notes: clock stands low between frames
`timescale 1ns/1ns
module fsrh_host (
  output logic sclk,
  output logic cs_n,
  output logic si
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si = 1'b1;
  end
  // bits launched while the clock is low, taken on its rise
  task automatic frame(input logic [7:0] b, input int n);
    #7;
    cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      si = b[7 - (i % 8)];
      #16 sclk = 1'b1;
      #16 sclk = 1'b0;
    end
    #16 cs_n = 1'b1;
    // released line shows the inverse so a stale bit is never read as valid
    si = ~si;
    #64;
  endtask
endmodule

// [bench/tb_fsrh_top.sv]
// Purpose: self-checking bench for fsrh_top
// Assumes: reduced counts, host model on the link
// Notes: expectations built from package constants
`timescale 1ns/1ns
module tb_fsrh_top;
  localparam int unsigned PW = 50;
  localparam int unsigned RC = 40;
  localparam int unsigned RE = 80;
  localparam logic [31:0] ST0 = {8'h00, fsrh_pkg::STATUS_RESET};
  localparam logic [31:0] WRITE_ENABLE_LATCH = 32'h00000001 << fsrh_pkg::ST_WEL;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, busy_flag, ready, reset_pulse, data_suspect, err;
  wire sclk, cs_n, si;
  int n_mismatch = 0;
  int cmp_count = 0;
  int n_pulse = 0;
  int cyc = 0;
  int n;
  always #10 pclk = ~pclk;
  fsrh_top #(.PWRUP_CYC(PW), .RST_CYC(RC), .RST_E_CYC(RE), .SUS_CYC(10)) fsrh_top_i (
    .pclk(pclk), .presetn(presetn), .sclk(sclk), .cs_n(cs_n), .si(si), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .busy_flag(busy_flag), .ready(ready),
    .reset_pulse(reset_pulse), .data_suspect(data_suspect));
  fsrh_host fsrh_host_i (.sclk(sclk), .cs_n(cs_n), .si(si));
  task automatic wrap_up();
    if (n_mismatch == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (reset_pulse === 1'b1) n_pulse <= n_pulse + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_ready(output int c);
    c = 0;
    while (ready !== 1'b1 && c < 3000) begin
      @(posedge pclk);
      c++;
    end
  endtask
  // poke sends a write-enable frame while recovery should refuse it
  task automatic rst_seq(input logic poke, output int c);
    int p;
    p = n_pulse;
    fsrh_host_i.frame(fsrh_pkg::OP_EN_RST, 8);
    fsrh_host_i.frame(fsrh_pkg::OP_RST, 8);
    if (poke) fsrh_host_i.frame(fsrh_pkg::OP_WREN, 8);
    repeat (12) @(posedge pclk);
    cmp(n_pulse - p, 1);
    wait_ready(c);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_boot();
    cmp(ready, 1'b0);
    wait_ready(n);
    cmp(n + 2 >= PW, 1);
    apb(1'b0, fsrh_pkg::A_STATUS, 32'h00000000);
    cmp(rd, ST0);
    apb(1'b0, 8'h14, 32'h00000000);
    cmp(err, 1'b1);
    cmp(rd, 32'h00000000);
  endtask
  task automatic t_suspend();
    apb(1'b1, fsrh_pkg::A_CTRL, 32'h00000001 << fsrh_pkg::C_START_PROG);
    fsrh_host_i.frame(fsrh_pkg::OP_SUSPEND, 8);
    repeat (20) @(posedge pclk);
    apb(1'b0, fsrh_pkg::A_STATUS, 32'h00000000);
    cmp(rd, ST0 | (32'h00000001 << fsrh_pkg::ST_SUS_PROG));
    fsrh_host_i.frame(fsrh_pkg::OP_RESUME, 8);
    repeat (12) @(posedge pclk);
    apb(1'b0, fsrh_pkg::A_STATUS, 32'h00000000);
    cmp(rd, ST0 | 32'h00000001);
    apb(1'b1, fsrh_pkg::A_CTRL, 32'h00000001 << fsrh_pkg::C_DONE);
    apb(1'b0, fsrh_pkg::A_STATUS, 32'h00000000);
    cmp(rd, ST0);
    cmp(busy_flag, 1'b0);
  endtask
  // deep power-down refuses the reset pair; only presetn brings it back
  task automatic t_deep();
    int p;
    p = n_pulse;
    fsrh_host_i.frame(fsrh_pkg::OP_DEEP_PD, 8);
    fsrh_host_i.frame(fsrh_pkg::OP_EN_RST, 8);
    fsrh_host_i.frame(fsrh_pkg::OP_RST, 8);
    repeat (12) @(posedge pclk);
    cmp(n_pulse - p, 0);
    apb(1'b0, fsrh_pkg::A_STATE, 32'h00000000);
    cmp(rd, 32'h00000092);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    cmp(ready, 1'b0);
    wait_ready(n);
    cmp(n + 2 >= PW, 1);
    apb(1'b0, fsrh_pkg::A_STATE, 32'h00000000);
    cmp(rd, 32'h00000012);
  endtask
  task automatic t_cancel();
    fsrh_host_i.frame(fsrh_pkg::OP_EN_RST, 8);
    fsrh_host_i.frame(fsrh_pkg::OP_WREN, 8);
    fsrh_host_i.frame(fsrh_pkg::OP_RST, 8);
    fsrh_host_i.frame(fsrh_pkg::OP_EN_RST, 8);
    fsrh_host_i.frame(fsrh_pkg::OP_RST, 7);
    fsrh_host_i.frame(fsrh_pkg::OP_WREN, 8);
    repeat (12) @(posedge pclk);
    cmp(n_pulse, 0);
  endtask
  task automatic t_reset();
    apb(1'b1, fsrh_pkg::A_VOLATILE, 32'hA5A5A5A5);
    apb(1'b0, fsrh_pkg::A_STATUS, 32'h00000000);
    cmp(rd, ST0 | WRITE_ENABLE_LATCH);
    rst_seq(1'b1, n);
    cmp(n > 0 && n <= RC, 1);
    apb(1'b0, fsrh_pkg::A_STATUS, 32'h00000000);
    cmp(rd, ST0);
    apb(1'b0, fsrh_pkg::A_VOLATILE, 32'h00000000);
    cmp(rd, 32'h00000000);
    cmp(data_suspect, 1'b0);
  endtask
  task automatic t_erase();
    apb(1'b1, fsrh_pkg::A_CTRL, 32'h00000001 << fsrh_pkg::C_START_ERASE);
    apb(1'b0, fsrh_pkg::A_STATUS, 32'h00000000);
    cmp(rd, ST0 | 32'h00000001);
    rst_seq(1'b0, n);
    cmp(n > RC, 1);
    cmp({busy_flag, data_suspect}, 2'b01);
  endtask
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_boot();
    t_cancel();
    t_reset();
    t_erase();
    t_suspend();
    t_deep();
    wrap_up();
  end
endmodule
